// [hdl/dmp_core.sv]
// Modulation source selector: registers, profiles, RAM playback,
// keying ramp and parameter routing to the synthesizer core.
// Assumes a single-cycle register strobe master and synchronous pins.
//
// Functional notes
// - Single tone takes one of eight profiles, chosen by pins, at next sync.
// - RAM mode starts when enabled and update strobe or profile change occurs.
// - RAM holds 1024 x 32 words, played out at a timer-set rate.
// - Eight RAM profiles pick sample destination, switched on next sync edge.
// - Polar samples split into 16-bit phase and 14-bit magnitude.
// - Enabled keying ramp owns the amplitude over every other source.
// - Ramp is 32 bits: all for frequency, top 16 phase, top 14 amplitude.
// - Ramp limits, rise and fall step sizes and rates are programmable.
// - Direction pin sets ramp slope; hold pin freezes the ramp.
// - Port sample is 16-bit data plus 2-bit destination code.
// - Port data is always unsigned binary.
// - Code 00: data 15..2 is amplitude, low two bits ignored.
// - Code 01: all 16 data bits are phase offset.
// - Code 10: data offsets the tuning word, aligned by frequency gain.
// - Gain 0 aligns data at LSB; each step shifts left one bit.
// - Code 11: data high byte plus scale bits 5..0, low byte plus phase bits 7..0.
// - Port clock runs at a quarter of DAC rate, the sync rate.
// - Capture on rising port clock edge, falling edge when inverted.
// - Disabled port clock output stays low; capture timing keeps running.
// - Gate is active high unless inverted; data taken only while true.
// - Gate false clears the data word or keeps the last one.
`default_nettype none
module dmp_core
  import dmp_pkg::*;
(
  input  wire logic           clk_sys,
  input  wire logic           reset,
  input  wire logic [7:0]     reg_addr,
  input  wire logic [31:0]    reg_wdata,
  input  wire logic           reg_wr,
  input  wire logic           reg_rd,
  output logic [31:0]         reg_rdata,
  input  wire logic [2:0]     profile_sel,
  input  wire logic           ramp_direction_pin,
  input  wire logic           ramp_hold_pin,
  input  wire logic           output_keying_pin,
  input  wire dmp_port_word_t port_in,
  input  wire logic           port_gate_input,
  output logic                port_data_clock,
  output dmp_dds_t            dds
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [31:0]       ctrl;
    logic [31:0]       freq_tuning_word;
    logic [15:0]       phase_offset_word;
    logic [13:0]       amp_scale_factor;
    dmp_ramp_cfg_t     rcfg;
    logic [13:0]       osk_step;
    logic [9:0]        ram_addr;
    logic [7:0][31:0]  prof_ftw;
    logic [7:0][31:0]  prof_pa;
    logic [7:0][31:0]  ram_prof;
    logic [2:0]        profile;
    logic              ram_run;
    logic [9:0]        ram_ptr;
    logic [9:0]        ram_tmr;
    logic [13:0]       osk_amp;
    dmp_dds_t          dds;
    logic [31:0]       rdata;
  } dmp_core_st_t;

  dmp_core_st_t   s_ff, nxt_s;
  logic [31:0]    ram_mem [1024];
  logic [31:0]    ram_q_ff;
  logic           ram_we;
  logic           sync_en;
  logic [31:0]    ramp_val;
  dmp_port_word_t pw;
  dmp_port_cfg_t  pcfg;

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function automatic logic [2:0] bank_of(input logic [7:0] a);
    bank_of = a[7:5];
  endfunction : bank_of

  function automatic logic [31:0] ram_word(input logic [31:0] rp, input int sel);
    case (sel)
      0:       ram_word = {22'h000000, rp[9:0]};
      1:       ram_word = {22'h000000, rp[19:10]};
      2:       ram_word = {22'h000000, rp[29:20]};
      default: ram_word = {30'h00000000, rp[31:30]};
    endcase
  endfunction : ram_word

  // ----------------------------------------
  // Sub-blocks
  // ----------------------------------------
  assign pcfg.pclk_en   = s_ff.ctrl[CB_PCLK_EN];
  assign pcfg.pclk_inv  = s_ff.ctrl[CB_PCLK_INV];
  assign pcfg.gate_inv  = s_ff.ctrl[CB_GATE_INV];
  assign pcfg.hold_last = s_ff.ctrl[CB_HOLD_LAST];

  dmp_port u_port (
    .clk_sys         (clk_sys),
    .reset           (reset),
    .cfg             (pcfg),
    .port_in         (port_in),
    .port_gate_input (port_gate_input),
    .sync_en         (sync_en),
    .port_data_clock (port_data_clock),
    .word            (pw)
  );

  dmp_ramp u_ramp (
    .clk_sys            (clk_sys),
    .reset              (reset),
    .sync_en            (sync_en),
    .enable             (s_ff.ctrl[CB_RMP_EN]),
    .cfg                (s_ff.rcfg),
    .ramp_direction_pin (ramp_direction_pin),
    .ramp_hold_pin      (ramp_hold_pin),
    .value              (ramp_val)
  );

  assign reg_rdata = s_ff.rdata;
  assign dds       = s_ff.dds;

  // ----------------------------------------
  // RAM array, kept outside the state record
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (ram_we) begin
      ram_mem[s_ff.ram_addr] <= reg_wdata;
    end
    ram_q_ff <= ram_mem[s_ff.ram_ptr];
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic        upd;
  logic        prof_chg;
  logic [31:0] rp;
  logic [31:0] np;
  logic [1:0]  rdst;
  logic [1:0]  gdst;
  logic        ram_on;
  logic        rmp_on;
  logic        pp_on;
  logic [31:0] fm_ofs;
  logic [2:0]  cur_prof;

  always_comb begin
    nxt_s    = s_ff;
    ram_we   = 1'b0;
    upd      = 1'b0;
    fm_ofs   = 32'h0000_0000;
    cur_prof = sync_en ? profile_sel : s_ff.profile;
    rp       = s_ff.ram_prof[s_ff.profile];
    np       = s_ff.ram_prof[profile_sel];
    rdst     = rp[31:30];
    gdst     = s_ff.ctrl[CB_RMP_DEST +: 2];
    ram_on   = s_ff.ctrl[CB_RAM_EN] & s_ff.ram_run;
    rmp_on   = s_ff.ctrl[CB_RMP_EN];
    pp_on    = s_ff.ctrl[CB_PP_EN];
    prof_chg = sync_en && (profile_sel != s_ff.profile);
    nxt_s.rdata = 32'h0000_0000;

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        OFS_CTRL:     nxt_s.ctrl       = reg_wdata;
        OFS_FTW:      nxt_s.freq_tuning_word        = reg_wdata;
        OFS_POW:      nxt_s.phase_offset_word        = reg_wdata[15:0];
        OFS_ASF:      nxt_s.amp_scale_factor        = reg_wdata[13:0];
        OFS_RMP_UP:   nxt_s.rcfg.upper = reg_wdata;
        OFS_RMP_LO:   nxt_s.rcfg.lower = reg_wdata;
        OFS_RMP_RSTP: nxt_s.rcfg.rstep = reg_wdata;
        OFS_RMP_FSTP: nxt_s.rcfg.fstep = reg_wdata;
        OFS_RMP_RATE: {nxt_s.rcfg.rrate, nxt_s.rcfg.frate} = reg_wdata;
        OFS_OSK_STEP: nxt_s.osk_step   = reg_wdata[13:0];
        OFS_RAM_ADDR: nxt_s.ram_addr   = reg_wdata[9:0];
        OFS_RAM_DATA: begin
          ram_we         = 1'b1;
          nxt_s.ram_addr = s_ff.ram_addr + 10'h001;
        end
        OFS_UPDATE:   upd = 1'b1;
        default: begin
          case (bank_of(reg_addr))
            BANK_PFTW:  nxt_s.prof_ftw[reg_addr[4:2]] = reg_wdata;
            BANK_PPA:   nxt_s.prof_pa[reg_addr[4:2]]  = reg_wdata;
            BANK_RPROF: nxt_s.ram_prof[reg_addr[4:2]] = reg_wdata;
            default:    nxt_s.rdata = 32'h0000_0000;
          endcase
        end
      endcase
    end

    // Register reads, answered one cycle later
    if (reg_rd) begin
      case (reg_addr)
        OFS_CTRL:     nxt_s.rdata = s_ff.ctrl;
        OFS_FTW:      nxt_s.rdata = s_ff.freq_tuning_word;
        OFS_POW:      nxt_s.rdata = {16'h0000, s_ff.phase_offset_word};
        OFS_ASF:      nxt_s.rdata = {18'h00000, s_ff.amp_scale_factor};
        OFS_RMP_UP:   nxt_s.rdata = s_ff.rcfg.upper;
        OFS_RMP_LO:   nxt_s.rdata = s_ff.rcfg.lower;
        OFS_RMP_RSTP: nxt_s.rdata = s_ff.rcfg.rstep;
        OFS_RMP_FSTP: nxt_s.rdata = s_ff.rcfg.fstep;
        OFS_RMP_RATE: nxt_s.rdata = {s_ff.rcfg.rrate, s_ff.rcfg.frate};
        OFS_OSK_STEP: nxt_s.rdata = {18'h00000, s_ff.osk_step};
        OFS_RAM_ADDR: nxt_s.rdata = {22'h000000, s_ff.ram_addr};
        OFS_ST_FREQ:  nxt_s.rdata = s_ff.dds.freq;
        OFS_ST_PA:    nxt_s.rdata = {s_ff.dds.phase, 2'h0, s_ff.dds.amp};
        OFS_STATUS:   nxt_s.rdata = {17'h00000, s_ff.ram_tmr[0], s_ff.ram_run, s_ff.profile, s_ff.ram_ptr};
        default: begin
          case (bank_of(reg_addr))
            BANK_PFTW:  nxt_s.rdata = s_ff.prof_ftw[reg_addr[4:2]];
            BANK_PPA:   nxt_s.rdata = s_ff.prof_pa[reg_addr[4:2]];
            BANK_RPROF: nxt_s.rdata = s_ff.ram_prof[reg_addr[4:2]];
            default:    nxt_s.rdata = 32'h0000_0000;
          endcase
        end
      endcase
    end

    // Profile pins sampled on the sync boundary only
    if (sync_en) begin
      nxt_s.profile = profile_sel;
    end

    // RAM playback
    if (!s_ff.ctrl[CB_RAM_EN]) begin
      nxt_s.ram_run = 1'b0;
    end else if (upd || prof_chg) begin
      nxt_s.ram_run = 1'b1;
      nxt_s.ram_ptr = 10'(ram_word(prof_chg ? np : rp, 0));
      nxt_s.ram_tmr = 10'h000;
    end else if (sync_en && s_ff.ram_run) begin
      if (s_ff.ram_tmr >= 10'(ram_word(rp, 2))) begin
        nxt_s.ram_tmr = 10'h000;
        nxt_s.ram_ptr = (s_ff.ram_ptr == 10'(ram_word(rp, 1))) ? 10'(ram_word(rp, 0))
                                                               : s_ff.ram_ptr + 10'h001;
      end else begin
        nxt_s.ram_tmr = s_ff.ram_tmr + 10'h001;
      end
    end

    // Keying ramp walks towards the scale factor or zero
    if (sync_en) begin
      if (output_keying_pin) begin
        nxt_s.osk_amp = (s_ff.amp_scale_factor - s_ff.osk_amp > s_ff.osk_step) ? s_ff.osk_amp + s_ff.osk_step : s_ff.amp_scale_factor;
      end else begin
        nxt_s.osk_amp = (s_ff.osk_amp > s_ff.osk_step) ? s_ff.osk_amp - s_ff.osk_step : 14'h0000;
      end
    end

    // Parameter routing, highest precedence last
    if (sync_en) begin
      // Unsigned data, zero-extended then shifted by the gain
      fm_ofs = {16'h0000, pw.data} << s_ff.ctrl[CB_FM_GAIN +: 4];
      nxt_s.dds.freq  = s_ff.prof_ftw[cur_prof];
      nxt_s.dds.phase = s_ff.prof_pa[cur_prof][31:16];
      nxt_s.dds.amp   = s_ff.prof_pa[cur_prof][13:0];
      if (pp_on) begin
        case (pw.dest)
          PD_AMP:   nxt_s.dds.amp   = pw.data[15:2];
          PD_PHASE: nxt_s.dds.phase = pw.data;
          PD_FREQ:  nxt_s.dds.freq  = s_ff.freq_tuning_word + fm_ofs;
          default: begin
            nxt_s.dds.amp   = {pw.data[15:8], s_ff.amp_scale_factor[5:0]};
            nxt_s.dds.phase = {pw.data[7:0], s_ff.phase_offset_word[7:0]};
          end
        endcase
      end
      if (rmp_on) begin
        case (gdst)
          SD_FREQ:  nxt_s.dds.freq  = ramp_val;
          SD_PHASE: nxt_s.dds.phase = ramp_val[31:16];
          default:  nxt_s.dds.amp   = ramp_val[31:18];
        endcase
      end
      if (ram_on) begin
        case (rdst)
          SD_FREQ:  nxt_s.dds.freq  = ram_q_ff;
          SD_PHASE: nxt_s.dds.phase = ram_q_ff[31:16];
          SD_AMP:   nxt_s.dds.amp   = ram_q_ff[31:18];
          default: begin
            nxt_s.dds.phase = ram_q_ff[31:16];
            nxt_s.dds.amp   = ram_q_ff[15:2];
          end
        endcase
      end
      if (s_ff.ctrl[CB_OSK_EN]) begin
        nxt_s.dds.amp = s_ff.osk_amp;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_ff      <= '0;
      s_ff.ctrl <= CTRL_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence read_req;
    reg_rd && !reg_wr;
  endsequence
  sequence read_ans;
    ##1 1'b1 ##1 (reg_rdata == 32'h0000_0000 || $past(reg_rd));
  endsequence
  AST_RD_ONLY: assert property (@(posedge clk_sys) disable iff (reset)
    read_req |-> read_ans)
    else $error("read data outside answer cycle");
  AST_PROFILE: assert property (@(posedge clk_sys) disable iff (reset)
    sync_en |=> s_ff.profile == $past(profile_sel))
    else $error("profile not taken at sync edge");
  AST_OSK_AMP: assert property (@(posedge clk_sys) disable iff (reset)
    sync_en && s_ff.ctrl[CB_OSK_EN] |=> dds.amp == $past(s_ff.osk_amp))
    else $error("keying ramp lost amplitude");
  AST_PP_AMP: assert property (@(posedge clk_sys) disable iff (reset)
    sync_en && pp_on && !rmp_on && !ram_on && !s_ff.ctrl[CB_OSK_EN] && pw.dest == PD_AMP
    |=> dds.amp == $past(pw.data[15:2]))
    else $error("port amplitude wrong");
  AST_PP_POLAR: assert property (@(posedge clk_sys) disable iff (reset)
    sync_en && pp_on && !rmp_on && !ram_on && pw.dest == PD_POLAR
    |=> dds.phase == {$past(pw.data[7:0]), $past(s_ff.phase_offset_word[7:0])})
    else $error("port polar phase wrong");
  AST_RAM_START: assert property (@(posedge clk_sys) disable iff (reset)
    s_ff.ctrl[CB_RAM_EN] && reg_wr && reg_addr == OFS_UPDATE |=> s_ff.ram_run)
    else $error("update did not start RAM playback");
endmodule : dmp_core
`default_nettype wire

// [hdl/dmp_pkg.sv]
// Shared constants and carrier types of the modulation source port.
// Assumes one 250 MHz clock (clk_sys) and a synchronous active-high reset.
`default_nettype none
package dmp_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam logic [1:0]  SYNC_LAST_PH = 2'h3;
  localparam logic [1:0]  FALL_CAP_PH  = 2'h1;
  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_FTW      = 8'h04;
  localparam logic [7:0]  OFS_POW      = 8'h08;
  localparam logic [7:0]  OFS_ASF      = 8'h0C;
  localparam logic [7:0]  OFS_RMP_UP   = 8'h10;
  localparam logic [7:0]  OFS_RMP_LO   = 8'h14;
  localparam logic [7:0]  OFS_RMP_RSTP = 8'h18;
  localparam logic [7:0]  OFS_RMP_FSTP = 8'h1C;
  localparam logic [7:0]  OFS_RMP_RATE = 8'h20;
  localparam logic [7:0]  OFS_OSK_STEP = 8'h24;
  localparam logic [7:0]  OFS_RAM_ADDR = 8'h28;
  localparam logic [7:0]  OFS_RAM_DATA = 8'h2C;
  localparam logic [7:0]  OFS_UPDATE   = 8'h30;
  localparam logic [7:0]  OFS_ST_FREQ  = 8'h34;
  localparam logic [7:0]  OFS_ST_PA    = 8'h38;
  localparam logic [7:0]  OFS_STATUS   = 8'h3C;
  localparam logic [2:0]  BANK_PFTW    = 3'h2;
  localparam logic [2:0]  BANK_PPA     = 3'h3;
  localparam logic [2:0]  BANK_RPROF   = 3'h4;
  // ----------------------------------------
  // Control fields and reset values
  // ----------------------------------------
  localparam int          CB_RAM_EN    = 0;
  localparam int          CB_RMP_EN    = 1;
  localparam int          CB_PP_EN     = 2;
  localparam int          CB_OSK_EN    = 3;
  localparam int          CB_PCLK_EN   = 4;
  localparam int          CB_PCLK_INV  = 5;
  localparam int          CB_GATE_INV  = 6;
  localparam int          CB_HOLD_LAST = 7;
  localparam int          CB_FM_GAIN   = 8;
  localparam int          CB_RMP_DEST  = 12;
  localparam logic [31:0] CTRL_RST     = 32'h0000_0010;
  // Port destination codes
  localparam logic [1:0]  PD_AMP       = 2'h0;
  localparam logic [1:0]  PD_PHASE     = 2'h1;
  localparam logic [1:0]  PD_FREQ      = 2'h2;
  localparam logic [1:0]  PD_POLAR     = 2'h3;
  // RAM and ramp destination codes
  localparam logic [1:0]  SD_FREQ      = 2'h0;
  localparam logic [1:0]  SD_PHASE     = 2'h1;
  localparam logic [1:0]  SD_AMP       = 2'h2;
  localparam logic [1:0]  SD_POLAR     = 2'h3;
  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] data;
    logic [1:0]  dest;
  } dmp_port_word_t;

  typedef struct packed {
    logic        pclk_en;
    logic        pclk_inv;
    logic        gate_inv;
    logic        hold_last;
  } dmp_port_cfg_t;

  typedef struct packed {
    logic [31:0] upper;
    logic [31:0] lower;
    logic [31:0] rstep;
    logic [31:0] fstep;
    logic [15:0] rrate;
    logic [15:0] frate;
  } dmp_ramp_cfg_t;

  typedef struct packed {
    logic [31:0] freq;
    logic [15:0] phase;
    logic [13:0] amp;
  } dmp_dds_t;
endpackage : dmp_pkg
`default_nettype wire

// [hdl/dmp_port.sv]
// Parallel port front end: sync divider, port clock, gated capture.
// Assumes port inputs are synchronous to clk_sys.
`default_nettype none
module dmp_port
  import dmp_pkg::*;
(
  input  wire logic           clk_sys,
  input  wire logic           reset,
  input  wire dmp_port_cfg_t  cfg,
  input  wire dmp_port_word_t port_in,
  input  wire logic           port_gate_input,
  output logic                sync_en,
  output logic                port_data_clock,
  output dmp_port_word_t      word
);
  typedef struct packed {
    logic [1:0]     phase;
    logic           pclk;
    dmp_port_word_t word;
  } dmp_port_st_t;

  dmp_port_st_t s_ff, nxt_s;
  logic         cap;
  logic         gate_true;

  assign sync_en         = (s_ff.phase == SYNC_LAST_PH);
  assign port_data_clock = s_ff.pclk;
  assign word            = s_ff.word;
  assign cap             = cfg.pclk_inv ? (s_ff.phase == FALL_CAP_PH) : sync_en;
  assign gate_true       = port_gate_input ^ cfg.gate_inv;

  always_comb begin
    nxt_s       = s_ff;
    nxt_s.phase = s_ff.phase + 2'h1;
    // Clock output gated only; capture phases keep running
    nxt_s.pclk  = cfg.pclk_en & ~nxt_s.phase[1];
    if (cap) begin
      if (gate_true) begin
        nxt_s.word = port_in;
      end else if (!cfg.hold_last) begin
        nxt_s.word.data = 16'h0000;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  sequence pclk_low2;
    !port_data_clock [*2];
  endsequence
  AST_PCLK_SHAPE: assert property (@(posedge clk_sys) disable iff (reset)
    cfg.pclk_en [*2] ##1 ($rose(port_data_clock) && cfg.pclk_en) |-> port_data_clock [*2] ##1 pclk_low2)
    else $error("port clock not two high, two low");
  AST_PCLK_OFF: assert property (@(posedge clk_sys) disable iff (reset)
    !cfg.pclk_en |=> !port_data_clock)
    else $error("port clock not held low when disabled");
  AST_GATE_TAKE: assert property (@(posedge clk_sys) disable iff (reset)
    cap && gate_true |=> word == $past(port_in))
    else $error("gated word not captured");
  AST_GATE_CLEAR: assert property (@(posedge clk_sys) disable iff (reset)
    cap && !gate_true |=> ($past(cfg.hold_last) ? $stable(word) : word.data == 16'h0000))
    else $error("gate false handling wrong");
endmodule : dmp_port
`default_nettype wire

// [hdl/dmp_ramp.sv]
// Ramp generator: 32-bit accumulator between two limits.
// Assumes sync_en is a one-cycle pulse at the sync rate.
`default_nettype none
module dmp_ramp
  import dmp_pkg::*;
(
  input  wire logic          clk_sys,
  input  wire logic          reset,
  input  wire logic          sync_en,
  input  wire logic          enable,
  input  wire dmp_ramp_cfg_t cfg,
  input  wire logic          ramp_direction_pin,
  input  wire logic          ramp_hold_pin,
  output logic [31:0]        value
);
  typedef struct packed {
    logic [31:0] acc;
    logic [15:0] tmr;
  } dmp_ramp_st_t;

  dmp_ramp_st_t s_ff, nxt_s;
  logic [32:0]  up_sum;
  logic [32:0]  dn_dif;

  assign value  = s_ff.acc;
  assign up_sum = {1'b0, s_ff.acc} + {1'b0, cfg.rstep};
  assign dn_dif = {1'b0, s_ff.acc} - {1'b0, cfg.fstep};

  always_comb begin
    nxt_s = s_ff;
    if (!enable) begin
      nxt_s.acc = cfg.lower;
      nxt_s.tmr = 16'h0000;
    end else if (sync_en && !ramp_hold_pin) begin
      if (s_ff.tmr >= (ramp_direction_pin ? cfg.rrate : cfg.frate)) begin
        nxt_s.tmr = 16'h0000;
        if (ramp_direction_pin) begin
          nxt_s.acc = (up_sum[32] || up_sum[31:0] > cfg.upper) ? cfg.upper : up_sum[31:0];
        end else begin
          nxt_s.acc = (dn_dif[32] || dn_dif[31:0] < cfg.lower) ? cfg.lower : dn_dif[31:0];
        end
      end else begin
        nxt_s.tmr = s_ff.tmr + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  AST_RAMP_HOLD: assert property (@(posedge clk_sys) disable iff (reset)
    enable && $past(enable) && ramp_hold_pin |=> $stable(value))
    else $error("ramp moved while held");
endmodule : dmp_ramp
`default_nettype wire

// [sim/dmp_user_drv.sv]
// User logic model that feeds the parallel port of the modulation source.
// Assumes the bench hands it a word, a gate level and a drive flag.
`default_nettype none
module dmp_user_drv
  import dmp_pkg::*;
(
  input  wire logic           clk_sys,
  input  wire logic           drive,
  input  wire dmp_port_word_t req_word,
  input  wire logic           req_gate,
  output var  dmp_port_word_t port_in,
  output logic                port_gate_input
);
  timeunit 1ns;
  timeprecision 100ps;
  initial port_in = '0;
  initial port_gate_input = 1'b0;
  // Gate moves only on clk_sys edges, so each rising gate clears setup and hold
  always @(posedge clk_sys) begin
    port_gate_input <= req_gate;
    // A released bus toggles its data every cycle; dest stays put
    if (drive)
      port_in <= req_word;
    else
      port_in.data <= ~port_in.data;
  end
endmodule : dmp_user_drv
`default_nettype wire

// [sim/dmp_core_tb.sv]
// Self-checking bench: register bus, port clock, port routing, gate, profiles.
// Assumes dmp_user_drv stands in for the user logic on the port.
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module dmp_core_tb
  import dmp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic           clk_sys = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, drv = 1'b0, gate = 1'b0;
  logic [7:0]     reg_addr = 8'h00;
  logic [31:0]    reg_wdata = 32'h0, reg_rdata;
  logic [2:0]     psel = 3'h0;
  logic           dir = 1'b0, hold = 1'b0, output_keying = 1'b0;
  logic           port_gate_input, pclk;
  dmp_port_word_t req = '0, port_in;
  dmp_dds_t       dds;
  int             n_mismatch = 0, n_compared = 0;
  always #2 clk_sys = ~clk_sys;
  dmp_user_drv u_dmp_user_drv (.clk_sys(clk_sys), .drive(drv), .req_word(req), .req_gate(gate),
    .port_in(port_in), .port_gate_input(port_gate_input));
  dmp_core u_dmp_core (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .profile_sel(psel), .ramp_direction_pin(dir),
    .ramp_hold_pin(hold), .output_keying_pin(output_keying), .port_in(port_in), .port_gate_input(port_gate_input),
    .port_data_clock(pclk), .dds(dds));
  task automatic finish_test;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test
  // Strobe drops with a one-cycle gap so no signal is assigned twice at one edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk_sys) reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk_sys) reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask : rd
  task automatic settle;
    repeat (12) @(posedge clk_sys);
    #1;
  endtask : settle
  task automatic port(input dmp_port_word_t w, input logic g, input logic d);
    req <= w; gate <= g; drv <= d;
    settle();
  endtask : port
  task automatic pclk_highs(input int e);
    int h;
    h = 0;
    repeat (8) begin
      @(posedge clk_sys) #1 h += int'(pclk);
    end
    `CHK(h, e)
  endtask : pclk_highs
  function automatic dmp_dds_t exp_dds(input dmp_port_word_t w, input logic [31:0] f, p, a, input logic [3:0] g);
    exp_dds.freq  = f + ({16'h0, w.data} << g);
    exp_dds.amp   = (w.dest == PD_POLAR) ? {w.data[15:8], a[5:0]} : w.data[15:2];
    exp_dds.phase = (w.dest == PD_POLAR) ? {w.data[7:0], p[7:0]} : w.data;
  endfunction : exp_dds
  // Watchdog cuts a hang short
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    finish_test();
  end
  initial begin
    logic [31:0] freq_tuning_word, pw, amp_scale_factor, pf[8], lo, up, rw;
    logic [3:0]  g;
    dmp_port_word_t w;
    dmp_dds_t    e;
    freq_tuning_word = $urandom(32'hE07D);
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    rd(OFS_CTRL, CTRL_RST);
    rd(8'hFC, 32'h0);
    pclk_highs(4);
    $display("test reset done");
    freq_tuning_word = $urandom; pw = $urandom; amp_scale_factor = $urandom;
    wr(OFS_FTW, freq_tuning_word); wr(OFS_POW, pw); wr(OFS_ASF, amp_scale_factor);
    for (int i = 0; i < 24; i++) begin
      g = (i == 2) ? 4'h0 : (i == 6) ? 4'hF : 4'($urandom);
      wr(OFS_CTRL, 32'h14 | (32'(g) << 8) | (i[2] ? 32'h20 : 32'h0));
      w.data = (i < 4) ? 16'hFFFF : 16'($urandom);
      w.dest = i[1:0];
      port(w, 1'b1, 1'b1);
      e = exp_dds(w, freq_tuning_word, pw, amp_scale_factor, g);
      if (w.dest == PD_AMP || w.dest == PD_POLAR) `CHK(dds.amp, e.amp)
      if (w.dest == PD_PHASE || w.dest == PD_POLAR) `CHK(dds.phase, e.phase)
      if (w.dest == PD_FREQ) `CHK(dds.freq, e.freq)
    end
    $display("test port routing done");
    w = '{data: 16'hABCD, dest: PD_AMP};
    wr(OFS_CTRL, 32'h04);
    pclk_highs(0);
    port(w, 1'b1, 1'b1);
    `CHK(dds.amp, w.data[15:2])
    port(w, 1'b0, 1'b0);
    `CHK(dds.amp, 14'h0)
    wr(OFS_CTRL, 32'h84);
    port(w, 1'b1, 1'b1);
    port(w, 1'b0, 1'b0);
    `CHK(dds.amp, w.data[15:2])
    wr(OFS_CTRL, 32'hC4);
    port('{data: 16'h5A5A, dest: PD_AMP}, 1'b0, 1'b1);
    `CHK(dds.amp, 14'h1696)
    port(w, 1'b1, 1'b0);
    `CHK(dds.amp, 14'h1696)
    $display("test gate done");
    wr(OFS_CTRL, 32'h10);
    for (int p = 0; p < 8; p++) begin
      pf[p] = $urandom;
      wr(8'h40 + 8'(4 * p), pf[p]);
    end
    for (int p = 7; p >= 0; p--) begin
      @(posedge clk_sys) psel <= 3'(p);
      repeat (6) @(posedge clk_sys);
      #1 `CHK(dds.freq, pf[p])
    end
    $display("test profiles done");
    lo = {1'b0, 31'($urandom)};
    up = lo | 32'h8000_0000;
    wr(OFS_RMP_LO, lo);
    wr(OFS_RMP_UP, up);
    wr(OFS_RMP_RSTP, 32'hFFFF_FFFF);
    wr(OFS_RMP_FSTP, 32'hFFFF_FFFF);
    @(posedge clk_sys) dir <= 1'b1;
    wr(OFS_CTRL, 32'h12);
    settle();
    `CHK(dds.freq, up)
    @(posedge clk_sys) hold <= 1'b1;
    dir <= 1'b0;
    settle();
    `CHK(dds.freq, up)
    @(posedge clk_sys) hold <= 1'b0;
    settle();
    `CHK(dds.freq, lo)
    @(posedge clk_sys) dir <= 1'b1;
    wr(OFS_CTRL, 32'h1012);
    settle();
    `CHK(dds.phase, up[31:16])
    wr(OFS_CTRL, 32'h2012);
    settle();
    `CHK(dds.amp, up[31:18])
    wr(OFS_OSK_STEP, 32'h3FFF);
    wr(OFS_CTRL, 32'h1C);
    @(posedge clk_sys) output_keying <= 1'b1;
    port(w, 1'b1, 1'b1);
    `CHK(dds.amp, amp_scale_factor[13:0])
    @(posedge clk_sys) output_keying <= 1'b0;
    settle();
    `CHK(dds.amp, 14'h0)
    rw = $urandom;
    wr(OFS_RAM_ADDR, 32'h0);
    wr(OFS_RAM_DATA, rw);
    wr(8'h80, 32'h0);
    wr(OFS_CTRL, 32'h11);
    wr(OFS_UPDATE, 32'h0);
    settle();
    `CHK(dds.freq, rw)
    wr(8'h80, 32'hC000_0000);
    wr(OFS_UPDATE, 32'h0);
    settle();
    `CHK(dds.phase, rw[31:16])
    `CHK(dds.amp, rw[15:2])
    $display("test sources done");
    finish_test();
  end
endmodule : dmp_core_tb
`default_nettype wire
